// file: src/event_select.sv
/*
  Event selection: compares the counter with the active timing values
  and picks the time base or the external input for each event.
  Assumes the external event inputs are synchronous one-cycle pulses.
*/
`timescale 1ns/100ps
`default_nettype none

module event_select
  import pwm_tb_pkg::*;
(
  // Time base
  input  wire logic [CNT_W-1:0] cnt,
  input  wire timing_t          act,
  input  wire logic             tick,
  input  wire logic             en,
  // Source selection, one per event, high selects the input
  input  wire evt_t             src_ext,
  input  wire evt_t             ext_evt,
  // Results
  output var evt_t              evt,
  output var match_t            match
);

  function automatic logic hit(input logic [CNT_W-1:0] a,
                               input logic [CNT_W-1:0] b);
    hit = (a == b);
  endfunction : hit

  logic sync_per;
  logic sync_rise;
  logic sync_fall;

  always_comb begin
    sync_per  = en && tick && hit(cnt, act.per);
    sync_rise = en && tick && hit(cnt, act.ph);
    sync_fall = en && tick && hit(cnt, act.duty);
    match.per_match = sync_per;
    match.ph_match  = sync_rise;
    evt.per  = src_ext.per  ? (en && ext_evt.per)  : sync_per;
    evt.rise = src_ext.rise ? (en && ext_evt.rise) : sync_rise;
    evt.fall = src_ext.fall ? (en && ext_evt.fall) : sync_fall;
  end

endmodule : event_select

`default_nettype wire

// file: src/mod_clk_div.sv
/*
  Modulator clock divider: one-cycle enable pulse every div+1 cycles.
  Assumes a single clock domain and an enable from the control logic.
*/
`timescale 1ns/100ps
`default_nettype none

module mod_clk_div
  import pwm_tb_pkg::*;
#(
  parameter int W = DIV_W
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Control
  input  wire logic         en,
  input  wire logic [W-1:0] div,
  // Tick
  output logic              tick
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } div_st_t;

  div_st_t q;
  div_st_t d;

  always_comb begin
    d = q;
    if (!en) begin
      // Held at zero so the first period starts cleanly on enable
      d.cnt  = '0;
      d.tick = 1'b0;
    end else if (q.cnt >= div) begin
      d.cnt  = '0;
      d.tick = 1'b1;
    end else begin
      d.cnt  = q.cnt + W'(1);
      d.tick = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;

endmodule : mod_clk_div

`default_nettype wire

// file: src/pwm_tb_pkg.sv
/*
  Package of the PWM time base: register map, field positions,
  reset values, carrier structs and state types.
  Assumes a 32-bit APB with byte addresses on an 8-bit PADDR.
*/
package pwm_tb_pkg;

  ////////////////////////////////////////////////////////////////////
  // Widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 16;
  localparam int DIV_W  = 8;
  localparam int INT_W  = 3;

  ////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [ADDR_W-1:0] REG_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] REG_CNT_LO  = 8'h04;
  localparam logic [ADDR_W-1:0] REG_CNT_HI  = 8'h08;
  localparam logic [ADDR_W-1:0] REG_PER_LO  = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_PER_HI  = 8'h10;
  localparam logic [ADDR_W-1:0] REG_PH_LO   = 8'h14;
  localparam logic [ADDR_W-1:0] REG_PH_HI   = 8'h18;
  localparam logic [ADDR_W-1:0] REG_DUTY_LO = 8'h1C;
  localparam logic [ADDR_W-1:0] REG_DUTY_HI = 8'h20;
  localparam logic [ADDR_W-1:0] REG_INT_ST  = 8'h24;
  localparam logic [ADDR_W-1:0] REG_INT_MSK = 8'h28;
  localparam logic [ADDR_W-1:0] REG_CLKDIV  = 8'h2C;

  ////////////////////////////////////////////////////////////////////
  // Control and interrupt bit positions
  localparam int CTRL_EN       = 0;
  localparam int CTRL_LD       = 1;
  localparam int CTRL_SRC_PER  = 2;
  localparam int CTRL_SRC_RISE = 3;
  localparam int CTRL_SRC_FALL = 4;
  localparam int INT_OVF       = 0;
  localparam int INT_PER       = 1;
  localparam int INT_PH        = 2;

  ////////////////////////////////////////////////////////////////////
  // Counter bounds and reset values
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_MAX  = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
  localparam logic [DIV_W-1:0] DIV_RST  = 8'h00;
  localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic [CNT_W-1:0] per;
    logic [CNT_W-1:0] ph;
    logic [CNT_W-1:0] duty;
  } timing_t;

  typedef struct packed {
    logic per;
    logic rise;
    logic fall;
  } evt_t;

  typedef struct packed {
    logic per_match;
    logic ph_match;
  } match_t;

  typedef enum logic [1:0] {
    APB_IDLE = 2'b01,
    APB_DONE = 2'b10
  } apb_st_t;

endpackage : pwm_tb_pkg

// file: src/pwm_time_base.sv
/*
  PWM time base and event generator with APB register access,
  double-buffered period, phase and duty, and a level interrupt.
  Assumes an APB master on CORE_CLK and synchronous event inputs.
*/
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - 16-bit counter counts up from zero by one per modulator tick.
// - Wrap from all ones without period event sets overflow flag.
// - Any period event, time base or external, clears the counter.
// - Clearing the module enable bit forces the counter to zero.
// - Counter equal to active period gives a period event.
// - Period match also sets the period match flag.
// - Period is buffered, copied to active at period event after load.
// - Buffered changes stay inactive until the period event after load.
// - Period, phase and duty become active together, never mixed.
// - Counter equal to active phase gives a rising edge event.
// - Phase match sets the phase match flag.
// - Phase is double buffered, moved at period event after load.
// - A period lasts the period value plus one modulator ticks.
// - Counter equal to active duty gives a falling edge event.
// - Each event comes from the time base or an external input.
// - Counter, period and phase are reached as low and high bytes.
module pwm_time_base
  import pwm_tb_pkg::*;
(
  // Clock and reset
  input  wire logic              CORE_CLK,
  input  wire logic              RESETN,
  // APB slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [DATA_W-1:0] PWDATA,
  input  wire logic [3:0]        PSTRB,
  output logic      [DATA_W-1:0] PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  // External event inputs
  input  wire logic              EXT_PERIOD,
  input  wire logic              EXT_RISE,
  input  wire logic              EXT_FALL,
  // Events and waveform
  output logic                   PERIOD_EVT,
  output logic                   RISE_EVT,
  output logic                   FALL_EVT,
  output logic                   PWM_OUT,
  // Interrupt
  output logic                   IRQ
);

  typedef struct packed {
    apb_st_t           apb;
    logic [DATA_W-1:0] rdata;
    logic              slverr;
    logic              en;
    logic              ld;
    evt_t              src;
    logic [DIV_W-1:0]  div;
    logic [CNT_W-1:0]  cnt;
    timing_t           bufv;
    timing_t           act;
    logic [INT_W-1:0]  stat;
    logic [INT_W-1:0]  mask;
    evt_t              evt_o;
    logic              pwm;
    logic              irq;
  } state_t;

  state_t q;
  state_t d;

  logic   tick;
  evt_t   evt;
  match_t match;
  evt_t   ext_in;
  logic   wr;
  logic   wr_lane;
  logic   ovf;
  logic [INT_W-1:0] set_int;
  logic [DATA_W-1:0] rd;
  logic   addr_ok;

  ////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [CNT_W-1:0] put_byte(
    input logic [CNT_W-1:0] old,
    input logic [7:0]       b,
    input logic             hi
  );
    put_byte = hi ? {b, old[7:0]} : {old[15:8], b};
  endfunction : put_byte

  function automatic logic [DATA_W-1:0] zx8(input logic [7:0] b);
    zx8 = {24'h00_0000, b};
  endfunction : zx8

  function automatic logic known(input logic [ADDR_W-1:0] a);
    case (a)
      REG_CTRL, REG_CNT_LO, REG_CNT_HI, REG_PER_LO, REG_PER_HI,
      REG_PH_LO, REG_PH_HI, REG_DUTY_LO, REG_DUTY_HI,
      REG_INT_ST, REG_INT_MSK, REG_CLKDIV: known = 1'b1;
      default: known = 1'b0;
    endcase
  endfunction : known

  ////////////////////////////////////////////////////////////////////
  // Submodules

  mod_clk_div #(
    .W (DIV_W)
  ) u_div (
    .clk   (CORE_CLK),
    .rst_n (RESETN),
    .en    (q.en),
    .div   (q.div),
    .tick  (tick)
  );

  assign ext_in = '{per: EXT_PERIOD, rise: EXT_RISE, fall: EXT_FALL};

  event_select u_evt (
    .cnt     (q.cnt),
    .act     (q.act),
    .tick    (tick),
    .en      (q.en),
    .src_ext (q.src),
    .ext_evt (ext_in),
    .evt     (evt),
    .match   (match)
  );

  ////////////////////////////////////////////////////////////////////
  // Read mux

  always_comb begin
    addr_ok = known(PADDR);
    rd      = RD_ZERO;
    case (PADDR)
      REG_CTRL: begin
        rd[CTRL_EN]       = q.en;
        rd[CTRL_LD]       = q.ld;
        rd[CTRL_SRC_PER]  = q.src.per;
        rd[CTRL_SRC_RISE] = q.src.rise;
        rd[CTRL_SRC_FALL] = q.src.fall;
      end
      REG_CNT_LO:  rd = zx8(q.cnt[7:0]);
      REG_CNT_HI:  rd = zx8(q.cnt[15:8]);
      REG_PER_LO:  rd = zx8(q.bufv.per[7:0]);
      REG_PER_HI:  rd = zx8(q.bufv.per[15:8]);
      REG_PH_LO:   rd = zx8(q.bufv.ph[7:0]);
      REG_PH_HI:   rd = zx8(q.bufv.ph[15:8]);
      REG_DUTY_LO: rd = zx8(q.bufv.duty[7:0]);
      REG_DUTY_HI: rd = zx8(q.bufv.duty[15:8]);
      REG_INT_ST:  rd[INT_W-1:0] = q.stat;
      REG_INT_MSK: rd[INT_W-1:0] = q.mask;
      REG_CLKDIV:  rd[DIV_W-1:0] = q.div;
      default:     rd = RD_ZERO;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d = q;
    // Write lands at the edge where the master samples PREADY high
    wr      = (q.apb == APB_DONE) && PSEL && PENABLE && PWRITE;
    wr_lane = wr && PSTRB[0] && addr_ok;

    // APB handshake, one wait state on every access
    case (q.apb)
      APB_IDLE: begin
        if (PSEL && PENABLE) begin
          d.apb    = APB_DONE;
          d.rdata  = PWRITE ? RD_ZERO : rd;
          d.slverr = !addr_ok;
        end
      end
      APB_DONE: begin
        d.apb    = APB_IDLE;
        d.rdata  = RD_ZERO;
        d.slverr = 1'b0;
      end
      default: begin
        d.apb = APB_IDLE;
      end
    endcase

    ovf = q.en && tick && (q.cnt == CNT_MAX) && !evt.per;

    // Time base counter
    if (!q.en) begin
      d.cnt = CNT_ZERO;
    end else if (evt.per) begin
      d.cnt = CNT_ZERO;
    end else if (tick) begin
      d.cnt = q.cnt + CNT_ONE;
    end

    if (evt.per && q.ld) begin
      d.act = q.bufv;
      d.ld  = 1'b0;
    end

    // Event outputs and waveform
    d.evt_o = evt;
    d.pwm   = q.en && ((q.pwm || evt.rise) && !evt.fall);

    set_int          = '0;
    set_int[INT_OVF] = ovf;
    set_int[INT_PER] = match.per_match;
    set_int[INT_PH]  = match.ph_match;

    // Software writes
    if (wr_lane) begin
      case (PADDR)
        REG_CTRL: begin
          d.en       = PWDATA[CTRL_EN];
          // Load can only be set by software; setting wins over clear
          d.ld       = d.ld || PWDATA[CTRL_LD];
          d.src.per  = PWDATA[CTRL_SRC_PER];
          d.src.rise = PWDATA[CTRL_SRC_RISE];
          d.src.fall = PWDATA[CTRL_SRC_FALL];
        end
        REG_CNT_LO: begin
          if (q.en && !evt.per) d.cnt = put_byte(q.cnt, PWDATA[7:0], 1'b0);
        end
        REG_CNT_HI: begin
          if (q.en && !evt.per) d.cnt = put_byte(q.cnt, PWDATA[7:0], 1'b1);
        end
        REG_PER_LO:
          d.bufv.per = put_byte(q.bufv.per, PWDATA[7:0], 1'b0);
        REG_PER_HI:
          d.bufv.per = put_byte(q.bufv.per, PWDATA[7:0], 1'b1);
        REG_PH_LO:
          d.bufv.ph = put_byte(q.bufv.ph, PWDATA[7:0], 1'b0);
        REG_PH_HI:
          d.bufv.ph = put_byte(q.bufv.ph, PWDATA[7:0], 1'b1);
        REG_DUTY_LO:
          d.bufv.duty = put_byte(q.bufv.duty, PWDATA[7:0], 1'b0);
        REG_DUTY_HI:
          d.bufv.duty = put_byte(q.bufv.duty, PWDATA[7:0], 1'b1);
        REG_INT_ST:
          d.stat = q.stat & ~PWDATA[INT_W-1:0];
        REG_INT_MSK:
          d.mask = PWDATA[INT_W-1:0];
        REG_CLKDIV:
          d.div = PWDATA[DIV_W-1:0];
        default: begin
          d.div = q.div;
        end
      endcase
    end

    d.stat = d.stat | set_int;
    d.irq  = |(d.stat & d.mask);
  end

  ////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      q        <= '0;
      q.apb    <= APB_IDLE;
      q.div    <= DIV_RST;
      q.cnt    <= CNT_ZERO;
    end else begin
      q <= d;
    end
  end

  assign PRDATA     = q.rdata;
  assign PREADY     = q.apb[1];
  assign PSLVERR    = q.slverr;
  assign PERIOD_EVT = q.evt_o.per;
  assign RISE_EVT   = q.evt_o.rise;
  assign FALL_EVT   = q.evt_o.fall;
  assign PWM_OUT    = q.pwm;
  assign IRQ        = q.irq;

  ////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESETN);

  chk_cnt_step: assert property (
    q.en && tick && !evt.per && !wr_lane
      |=> q.cnt == $past(q.cnt) + CNT_ONE)
    else $error("counter did not step by one");

  chk_ovf_flag: assert property (
    q.en && tick && q.cnt == CNT_MAX && !evt.per
      |=> q.stat[INT_OVF])
    else $error("overflow flag not set on wrap");

  chk_per_clear: assert property (
    evt.per |=> q.cnt == CNT_ZERO)
    else $error("period event did not clear counter");

  chk_dis_zero: assert property (
    !q.en |=> q.cnt == CNT_ZERO)
    else $error("counter not zero while disabled");

  chk_per_match: assert property (
    q.en && tick && !q.src.per && q.cnt == q.act.per
      |-> evt.per ##1 PERIOD_EVT)
    else $error("period match gave no event");

  chk_prif_set: assert property (
    match.per_match |=> q.stat[INT_PER])
    else $error("period match flag not set");

  chk_load_apply: assert property (
    evt.per && q.ld && !wr_lane |=> q.act == $past(q.bufv) && !q.ld)
    else $error("buffered values not applied together");

  chk_load_hold: assert property (
    !(evt.per && q.ld) |=> $stable(q.act))
    else $error("active values changed outside load");

  chk_ph_flag: assert property (
    q.en && tick && q.cnt == q.act.ph |=> q.stat[INT_PH])
    else $error("phase match flag not set");

  chk_fall_evt: assert property (
    q.en && tick && !q.src.fall && q.cnt == q.act.duty
      |=> FALL_EVT && !PWM_OUT)
    else $error("duty match gave no falling event");

  chk_ext_src: assert property (
    q.src.rise && q.en |-> evt.rise == EXT_RISE)
    else $error("external rising source ignored");

  chk_flag_sticky: assert property (
    q.stat[INT_PER] && !(wr && PADDR == REG_INT_ST)
      |=> q.stat[INT_PER])
    else $error("period flag dropped without clear");

  cov_load: cover property (evt.per && q.ld);
  cov_ovf: cover property (ovf);
  cov_irq: cover property (!IRQ ##1 IRQ);
  cov_ext_per: cover property (q.src.per && evt.per);

endmodule : pwm_time_base

`default_nettype wire

// file: tb/pwm_time_base_tb_top.sv
/*
  Self-checking testbench of the PWM time base: APB master tasks,
  one task per scenario, a single compare task and a watchdog.
  Assumes the register map and bit positions of pwm_tb_pkg.
*/
`timescale 1ns/100ps
`default_nettype none

module pwm_time_base_tb_top
  import pwm_tb_pkg::*;
;
  ////////////////////////////////////////////////////////////////////
  logic              core_clk;
  logic              resetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic [3:0]        pstrb;
  logic              pready;
  logic              pslverr;
  logic [2:0]        ext;
  logic              per_evt;
  logic              rise_evt;
  logic              fall_evt;
  logic              pwm_out;
  logic              irq;
  wire logic [2:0]   evts;
  logic [DATA_W-1:0] rd;
  logic              err;
  int                errors;
  int                comparisons;

  assign evts = {fall_evt, rise_evt, per_evt};

  pwm_time_base dut_u (
    .CORE_CLK   (core_clk),
    .RESETN     (resetn),
    .PSEL       (psel),
    .PENABLE    (penable),
    .PWRITE     (pwrite),
    .PADDR      (paddr),
    .PWDATA     (pwdata),
    .PSTRB      (pstrb),
    .PRDATA     (prdata),
    .PREADY     (pready),
    .PSLVERR    (pslverr),
    .EXT_PERIOD (ext[0]),
    .EXT_RISE   (ext[1]),
    .EXT_FALL   (ext[2]),
    .PERIOD_EVT (per_evt),
    .RISE_EVT   (rise_evt),
    .FALL_EVT   (fall_evt),
    .PWM_OUT    (pwm_out),
    .IRQ        (irq)
  );

  ////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic check(input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: %s seen %h expected %h",
               $time, msg, seen, exp);
    end
  endtask : check

  task automatic final_report;
    if (errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  // Request held until PREADY is sampled high; no latency assumed
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] exp, input string msg);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp, msg);
  endtask : rdchk

  // Edges counted until the chosen event pulse is seen, bounded
  task automatic wait_evt(input int i, output int n);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (evts[i] !== 1'b1 && n < 300);
  endtask : wait_evt

  ////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdchk(REG_CTRL, 32'h0000_0000, "control reset");
    rdchk(REG_PER_LO, 32'h0000_0000, "period reset");
    rdchk(REG_INT_ST, 32'h0000_0000, "status reset");
    rdchk(8'h30, 32'h0000_0000, "unmapped read");
    check(err, 1'b1, "unmapped error");
  endtask : t_reset

  task automatic t_period;
    int n;
    wr(REG_PER_LO, 32'h0000_0003);
    wr(REG_PH_LO, 32'h0000_0001);
    wr(REG_DUTY_LO, 32'h0000_0002);
    wr(REG_INT_MSK, 32'h0000_0000);
    wr(REG_CTRL, 32'h0000_0003);
    wait_evt(0, n);
    wait_evt(0, n);
    check(n, 32'h0000_0004, "period length");
    wait_evt(1, n);
    check(n, 32'h0000_0002, "rise offset");
    check(pwm_out, 1'b1, "pwm set by rise");
    wait_evt(2, n);
    check(n, 32'h0000_0001, "fall offset");
    check(pwm_out, 1'b0, "pwm cleared by fall");
    rdchk(REG_CTRL, 32'h0000_0001, "load bit");
    rdchk(REG_INT_ST, 32'h0000_0006, "flags unmasked");
    check(irq, 1'b0, "irq masked");
  endtask : t_period

  task automatic t_buffer;
    int n;
    wr(REG_PER_LO, 32'h0000_0007);
    rdchk(REG_PER_LO, 32'h0000_0007, "buffer readback");
    wait_evt(0, n);
    wait_evt(0, n);
    check(n, 32'h0000_0004, "period held");
    // Phase write gives a new buffered phase for the same load to apply
    wr(REG_PH_LO, 32'h0000_0005);
    wr(REG_CTRL, 32'h0000_0003);
    wait_evt(0, n);
    wait_evt(0, n);
    check(n, 32'h0000_0008, "new period");
    wait_evt(1, n);
    check(n, 32'h0000_0006, "new phase");
  endtask : t_buffer

  task automatic t_irq;
    wr(REG_INT_MSK, 32'h0000_0002);
    repeat (2) @(posedge core_clk);
    check(irq, 1'b1, "irq raised");
    wr(REG_CTRL, 32'h0000_0000);
    rdchk(REG_CNT_LO, 32'h0000_0000, "counter cleared");
    rdchk(REG_INT_ST, 32'h0000_0006, "flags sticky");
    wr(REG_INT_ST, 32'h0000_0007);
    rdchk(REG_INT_ST, 32'h0000_0000, "flags cleared");
    repeat (2) @(posedge core_clk);
    check(irq, 1'b0, "irq dropped");
  endtask : t_irq

  // Divided tick: period of seven takes eight ticks of two cycles
  task automatic t_divider;
    int n;
    wr(REG_CLKDIV, 32'h0000_0001);
    rdchk(REG_CLKDIV, 32'h0000_0001, "divider readback");
    wr(REG_CTRL, 32'h0000_0001);
    wait_evt(0, n);
    wait_evt(0, n);
    check(n, 32'h0000_0010, "divided period");
    wr(REG_CTRL, 32'h0000_0000);
    wr(REG_CLKDIV, 32'h0000_0000);
  endtask : t_divider

  task automatic t_overflow;
    wr(REG_CTRL, 32'h0000_0001);
    wr(REG_CNT_HI, 32'h0000_00FF);
    wr(REG_CNT_LO, 32'h0000_00F0);
    rdchk(REG_CNT_HI, 32'h0000_00FF, "counter high");
    repeat (40) @(posedge core_clk);
    wr(REG_CTRL, 32'h0000_0000);
    apb(1'b0, REG_INT_ST, 32'h0000_0000);
    check(rd[INT_OVF], 1'b1, "overflow flag");
    wr(REG_INT_ST, 32'h0000_0007);
  endtask : t_overflow

  task automatic t_external;
    for (int i = 0; i < 3; i++) begin
      wr(REG_CTRL, 32'h0000_0001 | (32'h0000_0004 << i));
      // Counter well past any small value before the pulse when the period source is external
      repeat (20) @(posedge core_clk);
      ext[i] <= 1'b1;
      @(posedge core_clk);
      ext[i] <= 1'b0;
      @(posedge core_clk);
      check(evts[i], 1'b1, "external event");
      if (i == 0) begin
        apb(1'b0, REG_CNT_LO, 32'h0000_0000);
        check(rd >> 3, 32'h0000_0000, "counter restarted");
      end
    end
    wr(REG_CTRL, 32'h0000_0000);
  endtask : t_external

  ////////////////////////////////////////////////////////////////////
  initial begin
    errors = 0;
    comparisons = 0;
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hF;
    ext = 3'b000;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    t_reset();
    t_period();
    t_buffer();
    t_irq();
    t_overflow();
    t_divider();
    t_external();
    final_report();
  end

  // Whole run takes a few hundred cycles; far beyond that is a hang
  initial begin
    #200000;
    errors++;
    final_report();
  end

endmodule : pwm_time_base_tb_top

`default_nettype wire
